/* uart_lcs_map.svh */
// Addresses, field positions, reset values and counts.
`ifndef UART_LCS_MAP_SVH
`define UART_LCS_MAP_SVH
`define ADDR_DATA        32'h40008000
`define ADDR_DIV_HIGH    32'h40008004
`define ADDR_LINE_CTRL   32'h4000800c
`define ADDR_LINE_STAT   32'h40008014
`define ADDR_EVT_STAT    32'h40008018
`define ADDR_EVT_MASK    32'h4000801c
`define LC_WLEN_HI       1
`define LC_WLEN_LO       0
`define LC_STOP          2
`define LC_PAR_EN        3
`define LC_PTYPE_HI      5
`define LC_PTYPE_LO      4
`define LC_BREAK         6
`define LC_DIVISOR_ACCESS_SELECT          7
`define LC_RESET         8'h00
`define LS_RDR           0
`define LS_OVR           1
`define LS_PERR          2
`define LS_THRE          5
`define LS_TEMT          6
`define EV_RDR           0
`define EV_OVR           1
`define EV_PERR          2
`define EV_THRE          3
`define EV_WIDTH         4
`define DIV_RESET        16'h0001
`define SUB_LAST         4'hf
`define SUB_MID          4'h7
`define STOP_ONE         5'h0f
`define STOP_HALF3       5'h17
`define STOP_TWO         5'h1f
`define FIFO_DEPTH       16
`define FIFO_AW          4
`endif

/* uart_lcs_pkg.sv */
// Types and the shared parity function of the line block.
package uart_lcs_pkg;
    typedef enum logic [2:0] {
        S_IDLE   = 3'h0,
        S_START  = 3'h1,
        S_DATA   = 3'h3,
        S_PARITY = 3'h2,
        S_STOP   = 3'h6
    } ser_state_t;

    typedef enum logic [1:0] {
        PT_ODD   = 2'h0,
        PT_EVEN  = 2'h1,
        PT_ONE   = 2'h2,
        PT_ZERO  = 2'h3
    } parity_type_t;

    // Parity over the active data bits only; word length code 0 means five bits.
    function automatic logic parity_bit(input logic [7:0] d, input logic [1:0] wlen,
                                        input parity_type_t pt);
        logic [7:0] m;
        logic       x;
        m = d & (8'hff >> (3'h3 - {1'b0, wlen}));
        x = ^m;
        unique case (pt)
            PT_ODD:  parity_bit = ~x;
            PT_EVEN: parity_bit = x;
            PT_ONE:  parity_bit = 1'b1;
            PT_ZERO: parity_bit = 1'b0;
        endcase
    endfunction
endpackage

/* uart_tx_serializer.sv */
// Transmit shifter of the line block.
`timescale 1ns/1ps
`include "uart_lcs_map.svh"
module uart_tx_serializer
    import uart_lcs_pkg::*;
(
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         rst,
    // Sixteen-times bit rate tick
    input  wire logic         tick16,
    // Character hand-over
    input  wire logic         start,
    input  wire logic [7:0]   data,
    // Framing
    input  wire logic [1:0]   word_len,
    input  wire logic         two_stop,
    input  wire logic         parity_en,
    input  wire parity_type_t parity_type,
    // Line side
    output logic              busy,
    output logic              line
);
    ser_state_t state;
    logic [3:0] sub;
    logic [4:0] stop_cnt;
    logic [2:0] bit_idx;
    logic [7:0] shift;
    logic       par;

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            state    <= S_IDLE;
            sub      <= 4'h0;
            stop_cnt <= 5'h00;
            bit_idx  <= 3'h0;
            shift    <= 8'h00;
            par      <= 1'b0;
            line     <= 1'b1;
        end
        else if (state == S_IDLE)
        begin
            if (start)
            begin
                state <= S_START;
                shift <= data;
                par   <= parity_bit(data, word_len, parity_type);
                sub   <= 4'h0;
                line  <= 1'b0;
            end
        end
        else if (tick16)
        begin
            sub <= sub + 4'h1;
            unique case (state)
                S_START:
                    if (sub == `SUB_LAST)
                    begin
                        state   <= S_DATA;
                        bit_idx <= 3'h0;
                        line    <= shift[0];
                    end
                S_DATA:
                    if (sub == `SUB_LAST)
                    begin
                        if (bit_idx == {1'b1, word_len})
                        begin
                            // Parity sits right after the last data bit.
                            if (parity_en)
                            begin
                                state <= S_PARITY;
                                line  <= par;
                            end
                            else
                            begin
                                state    <= S_STOP;
                                stop_cnt <= 5'h00;
                                line     <= 1'b1;
                            end
                        end
                        else
                        begin
                            bit_idx <= bit_idx + 3'h1;
                            line    <= shift[bit_idx + 3'h1];
                        end
                    end
                S_PARITY:
                    if (sub == `SUB_LAST)
                    begin
                        state    <= S_STOP;
                        stop_cnt <= 5'h00;
                        line     <= 1'b1;
                    end
                S_STOP:
                begin
                    stop_cnt <= stop_cnt + 5'h01;
                    // Stop length in sixteenths of a bit.
                    if (stop_cnt == (!two_stop ? `STOP_ONE :
                                     (word_len == 2'h0 ? `STOP_HALF3 : `STOP_TWO)))
                        state <= S_IDLE;
                end
                default:
                    state <= S_IDLE;
            endcase
        end
    end

    assign busy = (state != S_IDLE);
endmodule // uart_tx_serializer

/* uart_rx_deserializer.sv */
// Receive shifter of the line block.
`timescale 1ns/1ps
`include "uart_lcs_map.svh"
module uart_rx_deserializer
    import uart_lcs_pkg::*;
(
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         rst,
    // Sixteen-times bit rate tick
    input  wire logic         tick16,
    // Line side
    input  wire logic         line,
    // Framing
    input  wire logic [1:0]   word_len,
    input  wire logic         parity_en,
    input  wire parity_type_t parity_type,
    // Character out
    output logic              done,
    output logic [7:0]        data,
    output logic              parity_err
);
    ser_state_t state;
    logic [3:0] sub;
    logic [2:0] bit_idx;

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            state      <= S_IDLE;
            sub        <= 4'h0;
            bit_idx    <= 3'h0;
            data       <= 8'h00;
            parity_err <= 1'b0;
            done       <= 1'b0;
        end
        else
        begin
            done <= 1'b0;
            if (state == S_IDLE)
            begin
                if (!line)
                begin
                    state <= S_START;
                    sub   <= 4'h0;
                end
            end
            else if (tick16)
            begin
                sub <= sub + 4'h1;
                unique case (state)
                    S_START:
                        if (sub == `SUB_MID)
                        begin
                            // A start glitch shorter than half a bit is ignored.
                            state   <= line ? S_IDLE : S_DATA;
                            sub     <= 4'h0;
                            bit_idx <= 3'h0;
                            data    <= 8'h00;
                        end
                    S_DATA:
                        if (sub == `SUB_LAST)
                        begin
                            data[bit_idx] <= line;
                            bit_idx       <= bit_idx + 3'h1;
                            if (bit_idx == {1'b1, word_len})
                                state <= parity_en ? S_PARITY : S_STOP;
                        end
                    S_PARITY:
                        if (sub == `SUB_LAST)
                        begin
                            parity_err <= (line != parity_bit(data, word_len,
                                                              parity_type));
                            state      <= S_STOP;
                        end
                    S_STOP:
                        if (sub == `SUB_LAST)
                        begin
                            // The stop bit line level is not read; the frame ends in the middle of the first stop bit so back-to-back frames fit.
                            state <= S_IDLE;
                            done  <= 1'b1;
                            if (!parity_en)
                                parity_err <= 1'b0;
                        end
                    default:
                        state <= S_IDLE;
                endcase
            end
        end
    end
endmodule // uart_rx_deserializer

/* uart_line_control_status.sv */
// Line control and status block with register port and receive FIFO.
//
// Contract
// - Stop select 0 gives one stop bit; 1 gives two, or 1.5 for five-bit words.
// - Parity enable set means generate parity on transmit and check it on receive.
// - Parity type 0: ones in character plus parity bit are odd.
// - Parity type 1: ones in character plus parity bit are even.
// - Parity type 2 always sends 1; type 3 always sends 0.
// - Break control 1 holds the transmit line low; clearing it ends the break.
// - Divisor access 1 maps the divisor latches; 0 makes them unreachable.
// - Line status is read-only; writes change nothing.
// - Data ready is set while an unread character is held, cleared when FIFO empty.
// - Overrun sets at once when a character completes into a full FIFO.
// - A read of line status clears the overrun flag unless a new overrun arrives in the same cycle.
// - On overrun the FIFO stays intact and the new character is dropped.
`timescale 1ns/1ps
`include "uart_lcs_map.svh"
module uart_line_control_status
(
    // Clock and reset
    input  wire logic        CORE_CLK,
    input  wire logic        SYS_RST,
    // Register port
    input  wire logic [31:0] ADDR,
    input  wire logic [31:0] WR_DATA,
    input  wire logic        WR_EN,
    input  wire logic        RD_EN,
    output logic      [31:0] RD_DATA,
    // Serial line
    output logic             TXD,
    input  wire logic        RXD,
    // Interrupt
    output logic             IRQ
);
    import uart_lcs_pkg::*;

    logic [7:0]           line_control;
    logic [15:0]          divisor;
    logic [15:0]          div_cnt;
    logic                 tick16;

    logic [7:0]           tx_hold;
    logic                 tx_hold_full;
    logic                 tx_busy;
    logic                 tx_line;
    logic                 tx_start;

    logic                 rx_done;
    logic [7:0]           rx_data;
    logic                 rx_perr;

    logic [7:0]           fifo_mem [`FIFO_DEPTH];
    logic [`FIFO_AW-1:0]  wr_ptr;
    logic [`FIFO_AW-1:0]  rd_ptr;
    logic [`FIFO_AW:0]    fill;
    logic                 fifo_full;
    logic                 fifo_empty;

    logic                 overrun;
    logic                 perr_flag;
    logic [`EV_WIDTH-1:0] evt_stat;
    logic [`EV_WIDTH-1:0] evt_mask;
    logic [`EV_WIDTH-1:0] evt_set;

    logic                 divisor_access_select;
    logic                 wr_data_reg;
    logic                 rd_data_reg;
    logic                 rd_line_stat;
    logic                 push;
    logic                 pop;

    logic                 thre_d;
    logic [7:0]           line_stat;
    logic [31:0]          next_rd_data;

    assign divisor_access_select         = line_control[`LC_DIVISOR_ACCESS_SELECT];
    // The data word and the low divisor share one address; the access bit picks.
    assign wr_data_reg  = WR_EN && (ADDR == `ADDR_DATA) && !divisor_access_select;
    assign rd_data_reg  = RD_EN && (ADDR == `ADDR_DATA) && !divisor_access_select;
    assign rd_line_stat = RD_EN && (ADDR == `ADDR_LINE_STAT);

    assign fifo_full    = (fill == 5'(`FIFO_DEPTH));
    assign fifo_empty   = (fill == 5'h00);

    assign push         = rx_done && !fifo_full;
    assign pop          = rd_data_reg && !fifo_empty;
    assign tx_start     = tx_hold_full && !tx_busy;

    // Line control register; writable at all times.
    always_ff @(posedge CORE_CLK)
    begin
        if (SYS_RST)
        begin
            line_control <= `LC_RESET;
        end
        else if (WR_EN && ADDR == `ADDR_LINE_CTRL)
        begin
            line_control <= WR_DATA[7:0];
        end
    end

    // Divisor latches, reachable only while the access bit is set.
    always_ff @(posedge CORE_CLK)
    begin
        if (SYS_RST)
            divisor <= `DIV_RESET;
        else if (WR_EN && divisor_access_select)
        begin
            if (ADDR == `ADDR_DATA)
                divisor[7:0] <= WR_DATA[7:0];
            else if (ADDR == `ADDR_DIV_HIGH)
                divisor[15:8] <= WR_DATA[7:0];
        end
    end

    // Oversampling tick; a divisor of zero is treated as one so the line never stalls.
    always_ff @(posedge CORE_CLK)
    begin
        if (SYS_RST)
        begin
            div_cnt <= 16'h0000;
            tick16  <= 1'b0;
        end
        else if (div_cnt + 16'h0001 >= divisor)
        begin
            div_cnt <= 16'h0000;
            tick16  <= 1'b1;
        end
        else
        begin
            div_cnt <= div_cnt + 16'h0001;
            tick16  <= 1'b0;
        end
    end

    // Transmit holding register; a write while full replaces the waiting character.
    always_ff @(posedge CORE_CLK)
    begin
        if (SYS_RST)
        begin
            tx_hold      <= 8'h00;
            tx_hold_full <= 1'b0;
        end
        else if (wr_data_reg)
        begin
            tx_hold      <= WR_DATA[7:0];
            tx_hold_full <= 1'b1;
        end
        else if (tx_start)
            tx_hold_full <= 1'b0;
    end

    uart_tx_serializer u_tx (
        .clk         (CORE_CLK),
        .rst         (SYS_RST),
        .tick16      (tick16),
        .start       (tx_start),
        .data        (tx_hold),
        .word_len    (line_control[`LC_WLEN_HI:`LC_WLEN_LO]),
        .two_stop    (line_control[`LC_STOP]),
        .parity_en   (line_control[`LC_PAR_EN]),
        .parity_type (parity_type_t'(line_control[`LC_PTYPE_HI:`LC_PTYPE_LO])),
        .busy        (tx_busy),
        .line        (tx_line)
    );

    // The serializer keeps running under break so the frame timing is not disturbed.
    always_ff @(posedge CORE_CLK)
    begin
        if (SYS_RST)
        begin
            TXD <= 1'b1;
        end
        else
        begin
            TXD <= line_control[`LC_BREAK] ? 1'b0 : tx_line;
        end
    end

    uart_rx_deserializer u_rx (
        .clk         (CORE_CLK),
        .rst         (SYS_RST),
        .tick16      (tick16),
        .line        (RXD),
        .word_len    (line_control[`LC_WLEN_HI:`LC_WLEN_LO]),
        .parity_en   (line_control[`LC_PAR_EN]),
        .parity_type (parity_type_t'(line_control[`LC_PTYPE_HI:`LC_PTYPE_LO])),
        .done        (rx_done),
        .data        (rx_data),
        .parity_err  (rx_perr)
    );

    // Receive FIFO storage; a full FIFO refuses the new character.
    always_ff @(posedge CORE_CLK)
    begin
        if (push)
            fifo_mem[wr_ptr] <= rx_data;
    end

    always_ff @(posedge CORE_CLK)
    begin
        if (SYS_RST)
        begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            fill   <= '0;
        end
        else
        begin
            if (push)
                wr_ptr <= wr_ptr + 4'h1;
            if (pop)
                rd_ptr <= rd_ptr + 4'h1;
            if (push && !pop)
                fill <= fill + 5'h01;
            else if (pop && !push)
                fill <= fill - 5'h01;
        end
    end

    // Overrun and parity error are sticky; a new event in the clearing read wins.
    always_ff @(posedge CORE_CLK)
    begin
        if (SYS_RST)
        begin
            overrun   <= 1'b0;
            perr_flag <= 1'b0;
        end
        else
        begin
            if (rx_done && fifo_full)
                overrun <= 1'b1;
            else if (rd_line_stat)
                overrun <= 1'b0;
            if (push && rx_perr)
                perr_flag <= 1'b1;
            else if (rd_line_stat)
                perr_flag <= 1'b0;
        end
    end

    // Data ready follows the FIFO fill directly.
    always_comb
    begin
        line_stat           = 8'h00;
        line_stat[`LS_RDR]  = !fifo_empty;
        line_stat[`LS_OVR]  = overrun;
        line_stat[`LS_PERR] = perr_flag;
        line_stat[`LS_THRE] = !tx_hold_full;
        line_stat[`LS_TEMT] = !tx_hold_full && !tx_busy;
    end

    // Event status: set on each event, cleared by writing one, set wins.
    always_comb
    begin
        evt_set           = '0;
        evt_set[`EV_RDR]  = push;
        evt_set[`EV_OVR]  = rx_done && fifo_full;
        evt_set[`EV_PERR] = push && rx_perr;
        evt_set[`EV_THRE] = !tx_hold_full && !thre_d;
    end

    always_ff @(posedge CORE_CLK)
    begin
        if (SYS_RST)
        begin
            thre_d <= 1'b1;
        end
        else
        begin
            thre_d <= !tx_hold_full;
        end
    end

    always_ff @(posedge CORE_CLK)
    begin
        if (SYS_RST)
        begin
            evt_stat <= '0;
            evt_mask <= '0;
        end
        else
        begin
            if (WR_EN && ADDR == `ADDR_EVT_STAT)
                evt_stat <= (evt_stat & ~WR_DATA[`EV_WIDTH-1:0]) | evt_set;
            else
                evt_stat <= evt_stat | evt_set;
            if (WR_EN && ADDR == `ADDR_EVT_MASK)
                evt_mask <= WR_DATA[`EV_WIDTH-1:0];
        end
    end

    always_ff @(posedge CORE_CLK)
    begin
        if (SYS_RST)
        begin
            IRQ <= 1'b0;
        end
        else
        begin
            IRQ <= |(evt_stat & evt_mask);
        end
    end

    // Read mux; line status has no write path at all.
    always_comb
    begin
        next_rd_data = 32'h00000000;
        unique case (ADDR)
            `ADDR_DATA:
                next_rd_data[7:0] = divisor_access_select ? divisor[7:0] : fifo_mem[rd_ptr];
            `ADDR_DIV_HIGH:
                next_rd_data[7:0] = divisor_access_select ? divisor[15:8] : 8'h00;
            `ADDR_LINE_CTRL:
                next_rd_data[7:0] = line_control;
            `ADDR_LINE_STAT:
                next_rd_data[7:0] = line_stat;
            `ADDR_EVT_STAT:
                next_rd_data[`EV_WIDTH-1:0] = evt_stat;
            `ADDR_EVT_MASK:
                next_rd_data[`EV_WIDTH-1:0] = evt_mask;
            default:
                next_rd_data = 32'h00000000;
        endcase
        if (ADDR == `ADDR_DATA && !divisor_access_select && fifo_empty)
            next_rd_data = 32'h00000000;
    end

    // Read data stand only in the cycle after the strobe.
    always_ff @(posedge CORE_CLK)
    begin
        if (SYS_RST)
        begin
            RD_DATA <= 32'h00000000;
        end
        else if (RD_EN)
        begin
            RD_DATA <= next_rd_data;
        end
        else
        begin
            RD_DATA <= 32'h00000000;
        end
    end
endmodule // uart_line_control_status

/* uart_lcs_properties.sv */
// Port-level checker of the line block.
`timescale 1ns/1ps
`include "uart_lcs_map.svh"
module uart_lcs_properties (
    // Port signals
    input wire logic        CORE_CLK,
    input wire logic        SYS_RST,
    input wire logic [31:0] ADDR,
    input wire logic [31:0] WR_DATA,
    input wire logic        WR_EN,
    input wire logic        RD_EN,
    input wire logic [31:0] RD_DATA,
    input wire logic        TXD,
    input wire logic        IRQ
);
    logic [7:0] lc;
    logic [3:0] msk;
    logic       hit;
    assign hit = ADDR inside {`ADDR_DATA, `ADDR_DIV_HIGH, `ADDR_LINE_CTRL, `ADDR_LINE_STAT,
                              `ADDR_EVT_STAT, `ADDR_EVT_MASK};
    always_ff @(posedge CORE_CLK)
    begin
        if (SYS_RST)
        begin
            lc <= 8'h00;
            msk <= 4'h0;
        end
        else if (WR_EN && ADDR == `ADDR_LINE_CTRL)
            lc <= WR_DATA[7:0];
        else if (WR_EN && ADDR == `ADDR_EVT_MASK)
            msk <= WR_DATA[3:0];
    end
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (SYS_RST);
    a_rd_idle_zero: assert property (!$past(RD_EN) |-> RD_DATA == 32'h0)
        else $error("read data outside answer");
    a_unmapped_zero: assert property ($past(RD_EN && !hit) |-> RD_DATA == 32'h0)
        else $error("unmapped read nonzero");
    a_ctrl_readback: assert property (
        $past(RD_EN && ADDR == `ADDR_LINE_CTRL) |-> RD_DATA == {24'h0, $past(lc)})
        else $error("control readback wrong");
    a_status_upper: assert property (
        $past(RD_EN && ADDR == `ADDR_LINE_STAT) |-> RD_DATA[31:7] == 25'h0)
        else $error("line status upper bits set");
    a_div_hidden: assert property (
        $past(RD_EN && ADDR == `ADDR_DIV_HIGH && !lc[7]) |-> RD_DATA == 32'h0)
        else $error("divisor high visible");
    a_break_low: assert property (lc[6] && $past(lc[6]) |-> !TXD)
        else $error("line high in break");
    a_start_bit: assert property (
        $fell(TXD) && !lc[6] |-> (!TXD) [*8] ##1 (!TXD) [*8])
        else $error("start bit too short");
    a_irq_masked: assert property (msk == 4'h0 && $past(msk) == 4'h0 |-> !IRQ)
        else $error("interrupt while masked");
endmodule // uart_lcs_properties
bind uart_line_control_status uart_lcs_properties u_props (.CORE_CLK, .SYS_RST, .ADDR,
    .WR_DATA, .WR_EN, .RD_EN, .RD_DATA, .TXD, .IRQ);

/* uart_remote_port.sv */
// Remote serial port model on the far side of the line.
`timescale 1ns/1ps
module uart_remote_port (
    // Clock
    input wire logic clk,
    // Serial lines
    input wire logic txd,
    output logic     rxd
);
    initial rxd = 1'b1;
    task automatic send(input logic [10:0] bits, input int n);
        for (int k = 0; k < n; k++)
        begin
            rxd <= bits[k];
            repeat (16) @(posedge clk);
        end
    endtask
    task automatic catch(input int n, output logic [10:0] bits, output int hc);
        int w = 0;
        bits = 11'h0;
        hc = 0;
        while (txd === 1'b1 && w < 3000)
        begin
            @(posedge clk);
            w++;
        end
        repeat (8) @(posedge clk);
        for (int k = 0; k < n; k++)
        begin
            bits[k] = txd;
            if (k < n - 1)
                repeat (16) @(posedge clk);
        end
        repeat (8) @(posedge clk);
        while (txd === 1'b1 && hc < 100)
        begin
            @(posedge clk);
            hc++;
        end
    endtask
endmodule // uart_remote_port

/* uart_line_control_status_tb.sv */
// Self-checking bench of the line control and status block.
`timescale 1ns/1ps
`include "uart_lcs_map.svh"
module uart_line_control_status_tb;
    logic        CORE_CLK, SYS_RST, WR_EN, RD_EN, RXD, TXD, IRQ, pe;
    logic [31:0] ADDR, WR_DATA, RD_DATA, d;
    logic [15:0] seed;
    logic [10:0] bits;
    logic [7:0]  q [$];
    int          failures, checks, hc, nb, st;
    uart_line_control_status u_dut (.CORE_CLK, .SYS_RST, .ADDR, .WR_DATA, .WR_EN, .RD_EN,
        .RD_DATA, .TXD, .RXD, .IRQ);
    uart_remote_port u_peer (.clk(CORE_CLK), .txd(TXD), .rxd(RXD));
    initial
    begin
        CORE_CLK = 1'b0;
        forever #50 CORE_CLK = ~CORE_CLK;
    end
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    function automatic logic [10:0] frame(input logic [7:0] c, input int n, input logic p,
                                          input logic [1:0] pt);
        logic [10:0] f;
        f = {2'h0, c, 1'b0} & ((11'h2 << n) - 11'h1);
        if (p)
            f[n + 1] = (pt == 2'h0) ? ~^f : (pt == 2'h1) ? ^f : ~pt[0];
        return f;
    endfunction
    task automatic wrap_up();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e)
        begin
            failures++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wr(input logic [31:0] a, input logic [31:0] v);
        @(posedge CORE_CLK);
        ADDR <= a;
        WR_DATA <= v;
        WR_EN <= 1'b1;
        @(posedge CORE_CLK);
        WR_EN <= 1'b0;
    endtask
    task automatic rd(input logic [31:0] a, output logic [31:0] v);
        @(posedge CORE_CLK);
        ADDR <= a;
        RD_EN <= 1'b1;
        @(posedge CORE_CLK);
        RD_EN <= 1'b0;
        #1 v = RD_DATA;
    endtask
    task automatic rdc(input string nm, input logic [31:0] a, m, e);
        rd(a, d);
        chk(nm, e, d & m);
    endtask
    task automatic poll(input logic [31:0] a, input logic [31:0] m);
        int w = 0;
        rd(a, d);
        while ((d & m) !== m && w < 500)
        begin
            rd(a, d);
            w++;
        end
        if (w == 500)
        begin
            failures++;
            wrap_up();
        end
    endtask
    task automatic rx(input logic [7:0] c, input logic p, input logic bad);
        logic [10:0] f;
        f = frame(c, 8, p, 2'h1);
        f[9] = p ? f[9] ^ bad : 1'b1;
        f[10] = 1'b1;
        u_peer.send(f, 11);
    endtask
    initial
    begin
        {SYS_RST, WR_EN, RD_EN} = 3'b100;
        ADDR = 32'h0;
        WR_DATA = 32'h0;
        seed = 16'h0007;
        repeat (12) @(posedge CORE_CLK);
        SYS_RST <= 1'b0;
        rdc("ctrl", `ADDR_LINE_CTRL, 32'hff, 32'h0);
        rdc("stat", `ADDR_LINE_STAT, 32'h67, 32'h60);
        wr(`ADDR_LINE_STAT, 32'hff);
        rdc("stat_ro", `ADDR_LINE_STAT, 32'h67, 32'h60);
        rdc("unmapped", 32'h40008020, 32'hffffffff, 32'h0);
        wr(`ADDR_DIV_HIGH, 32'h33);
        rdc("div_off", `ADDR_DIV_HIGH, 32'hff, 32'h0);
        wr(`ADDR_LINE_CTRL, 32'h80);
        rdc("div_hi", `ADDR_DIV_HIGH, 32'hff, 32'h0);
        rdc("div_lo", `ADDR_DATA, 32'hff, 32'h1);
        wr(`ADDR_DIV_HIGH, 32'h5a);
        rdc("div_set", `ADDR_DIV_HIGH, 32'hff, 32'h5a);
        wr(`ADDR_DIV_HIGH, 32'h0);
        wr(`ADDR_LINE_CTRL, 32'h0);
        for (int i = 0; i < 8; i++)
        begin
            seed = lfsr(seed);
            nb = 5 + seed[1:0];
            st = !seed[2] ? 16 : (seed[1:0] == 2'h0) ? 24 : 32;
            pe = (i < 4) | seed[3];
            fork
                u_peer.catch(nb + 1 + pe, bits, hc);
                begin
                    wr(`ADDR_LINE_CTRL, {26'h0, i[1:0], pe, seed[2:0]});
                    wr(`ADDR_DATA, {24'h0, seed[15:8]});
                    wr(`ADDR_DATA, 32'h55);
                end
            join
            chk("frame", frame(seed[15:8], nb, pe, i[1:0]), bits);
            chk("stop", st, (hc >= st - 1 && hc <= st + 4) ? st : hc);
            poll(`ADDR_LINE_STAT, 32'h40);
        end
        wr(`ADDR_LINE_CTRL, 32'h40);
        repeat (3) @(posedge CORE_CLK);
        chk("break", 32'h0, TXD);
        wr(`ADDR_LINE_CTRL, 32'h0);
        repeat (3) @(posedge CORE_CLK);
        chk("unbreak", 32'h1, TXD);
        wr(`ADDR_LINE_CTRL, 32'h1b);
        rx(8'ha6, 1'b1, 1'b0);
        poll(`ADDR_EVT_STAT, 32'h1);
        rdc("ready", `ADDR_LINE_STAT, 32'h7, 32'h1);
        rdc("rbuf", `ADDR_DATA, 32'hff, 32'ha6);
        rdc("empty", `ADDR_LINE_STAT, 32'h7, 32'h0);
        rx(8'h3c, 1'b1, 1'b1);
        poll(`ADDR_EVT_STAT, 32'h4);
        rdc("perr", `ADDR_LINE_STAT, 32'h7, 32'h5);
        rdc("pop", `ADDR_DATA, 32'hff, 32'h3c);
        wr(`ADDR_LINE_CTRL, 32'h03);
        wr(`ADDR_EVT_STAT, 32'hf);
        for (int i = 0; i < 17; i++)
        begin
            seed = lfsr(seed);
            q.push_back(seed[7:0]);
            rx(seed[7:0], 1'b0, 1'b0);
        end
        poll(`ADDR_EVT_STAT, 32'h2);
        chk("irq_off", 32'h0, IRQ);
        rdc("ovr", `ADDR_LINE_STAT, 32'h3, 32'h3);
        rdc("ovr_clr", `ADDR_LINE_STAT, 32'h3, 32'h1);
        for (int i = 0; i < 16; i++)
            rdc("fifo", `ADDR_DATA, 32'hff, {24'h0, q[i]});
        rdc("drained", `ADDR_LINE_STAT, 32'h1, 32'h0);
        rdc("events", `ADDR_EVT_STAT, 32'h3, 32'h3);
        wr(`ADDR_EVT_MASK, 32'h2);
        repeat (2) @(posedge CORE_CLK);
        chk("irq_on", 32'h1, IRQ);
        wr(`ADDR_EVT_STAT, 32'h2);
        repeat (2) @(posedge CORE_CLK);
        chk("irq_clr", 32'h0, IRQ);
        rdc("evt_left", `ADDR_EVT_STAT, 32'h3, 32'h1);
        wrap_up();
    end
endmodule // uart_line_control_status_tb
